/* verilog/crf_cfg.svh */
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH
// register file geometry
`define CRF_NUM_REGS 32
`define CRF_IDX_W 5
// pointer pair low registers
`define CRF_PTR0_LO 5'h1A
`define CRF_PTR1_LO 5'h1C
`define CRF_PTR2_LO 5'h1E
// data space map
`define CRF_IO_BASE 16'h0020
`define CRF_IO_LAST 16'h005F
`define CRF_REG_LAST 16'h001F
// status bit positions
`define CRF_SF_I 7
`define CRF_SF_T 6
`define CRF_SF_H 5
`define CRF_SF_S 4
`define CRF_SF_V 3
`define CRF_SF_N 2
`define CRF_SF_Z 1
`define CRF_SF_C 0
`define CRF_SF_RESET 8'h00
// stack steps
`define CRF_SP_BYTE 16'h0001
`define CRF_SP_RET 16'h0002
`define CRF_SP_RESET 16'h0000
`endif

/* verilog/crf_pkg.sv */
package crf_pkg;
	typedef enum logic [2:0]
	{
		CRF_ALU_NONE,
		CRF_ALU_ADD,
		CRF_ALU_SUB,
		CRF_ALU_AND,
		CRF_ALU_OR,
		CRF_ALU_XOR,
		CRF_ALU_MOV
	} crf_alu_op_t;

	typedef enum logic [1:0]
	{
		CRF_PTR_DISP,
		CRF_PTR_POSTINC,
		CRF_PTR_PREDEC
	} crf_ptr_mode_t;

	typedef enum logic [2:0]
	{
		CRF_SP_NONE,
		CRF_SP_PUSH,
		CRF_SP_POP,
		CRF_SP_CALL,
		CRF_SP_RET
	} crf_sp_op_t;

	// port arrangement of one cycle
	typedef enum logic [1:0]
	{
		CRF_W_NONE,
		CRF_W_BYTE,
		CRF_W_WORD
	} crf_wr_kind_t;

	typedef struct packed
	{
		crf_alu_op_t alu_op;
		logic [4:0] rd;
		logic [4:0] rr;
		logic use_imm;
		logic [7:0] imm;
		logic carry_in;
		logic word_op;
		logic [15:0] word_val;
	} crf_exec_t;

	typedef struct packed
	{
		logic en;
		logic [1:0] sel;
		crf_ptr_mode_t mode;
		logic [5:0] disp;
	} crf_ptr_req_t;

	typedef struct packed
	{
		logic bit_store_instr;
		logic bit_load_instr;
		logic [4:0] reg_sel;
		logic [2:0] bit_sel;
		logic set_irq_enable_instr;
		logic clear_irq_enable_instr;
		logic return_from_irq_instr;
		logic sf_write;
		logic [7:0] sf_wdata;
	} crf_ctl_t;
endpackage : crf_pkg

/* verilog/crf_irq_pick.sv */
`timescale 1ns/1ps
// lowest vector wins among pending sources
module crf_irq_pick
	import crf_pkg::*;
#(
	parameter int NSRC = 8,
	parameter int VW = 3
)
(
	input wire logic [NSRC-1:0] pending,
	output logic any,
	output logic [VW-1:0] vec
);
	logic [NSRC-1:0] lower_hit;
	genvar g;
	generate
		for (g = 0; g < NSRC; g++)
		begin : g_pri
			if (g == 0)
			begin : g_first
				assign lower_hit[g] = 1'b0;
			end
			else
			begin : g_rest
				assign lower_hit[g] = lower_hit[g-1] | pending[g-1];
			end
		end
	endgenerate

	always_comb
	begin
		vec = '0;
		for (int i = 0; i < NSRC; i++)
		begin
			if (pending[i] && !lower_hit[i])
			begin
				vec = VW'(i);
			end
		end
	end
	assign any = |pending;
endmodule : crf_irq_pick

/* verilog/crf_core.sv */
`timescale 1ns/1ps
`include "crf_cfg.svh"
//
// Behaviour
// - fetch of next word overlaps execution; one instruction per cycle.
// - thirty-two 8-bit registers, each read and written in one cycle.
// - two operands read, result computed and written back in one cycle.
// - registers 26..31 form three 16-bit pointers; third also addresses program tables.
// - pointer modes: fixed displacement, post-increment, pre-decrement with write-back.
// - data addresses 0x00..0x1F map onto the general registers.
// - 64 I/O locations, direct or at data addresses 0x20..0x5F.
// - ports: 8r/8w, 2x8r/8w, 2x8r/16w, 16r/16w.
// - status flags updated after every ALU operation except move.
// - status register not saved or restored around interrupts.
// - status bit 7 is global interrupt enable; clear blocks all interrupts.
// - interrupt entry clears enable; return-from-interrupt sets it.
// - set and clear instructions drive the enable bit.
// - bit 6 is bit-copy store for bit-store and bit-load.
// - bit 5 is half carry out of low nibble.
// - bit 4 equals negative xor overflow.
// - bit 3 is two's complement overflow; bit 0 is carry.
// - bit 2 is negative; bit 1 is zero result.
// - lowest-vector pending interrupt served first.
// - call or interrupt pushes return address onto data-space stack; nothing is pushed while sp_load is set.
// - instructions are one or two 16-bit words.
// - stack pointer steps one for byte push/pop, two for return address.
module crf_core
	import crf_pkg::*;
#(
	parameter int NSRC = 8,
	parameter int VW = 3
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] fetch_word,
	input wire logic advance,
	input wire crf_exec_t exec,
	input wire crf_ptr_req_t ptr_req,
	input wire crf_ctl_t ctl,
	input wire crf_sp_op_t sp_op,
	input wire logic sp_load,
	input wire logic [15:0] sp_wdata,
	input wire logic [15:0] ret_pc,
	input wire logic [NSRC-1:0] irq_pending,
	input wire logic [7:0] io_rdata,
	output logic [15:0] instr_reg,
	output logic [7:0] rd_data,
	output logic [7:0] rr_data,
	output logic [7:0] core_status_flags,
	output logic [15:0] ptr_addr,
	output logic ptr_is_reg,
	output logic ptr_is_io,
	output logic [5:0] io_addr,
	output logic [7:0] ptr_reg_data,
	output logic [15:0] table_addr,
	output logic [15:0] sp_reg,
	output logic [15:0] stack_addr,
	output logic [15:0] stack_data,
	output logic stack_we,
	output logic irq_take,
	output logic [VW-1:0] irq_vec
);
	// ==========================================================
	// storage
	logic [7:0] gpr_reg [`CRF_NUM_REGS];
	logic [7:0] sf_reg;
	logic [7:0] sf_next;
	logic [7:0] op_a;
	logic [7:0] op_b;
	logic [8:0] sum;
	logic [7:0] res;
	logic c_f;
	logic h_f;
	logic v_f;
	logic flags_upd;
	logic [15:0] ptr_cur;
	logic [15:0] ptr_new;
	logic [15:0] ptr_eff;
	logic [4:0] ptr_lo_idx;
	logic pick_any;
	logic [VW-1:0] pick_vec;
	logic take;
	logic [7:0] bit_src;

	// ==========================================================
	// fetch stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			instr_reg <= 16'h0000;
		end
		else if (advance)
		begin
			instr_reg <= fetch_word;
		end
	end

	// ==========================================================
	// operand read and alu
	assign op_a = gpr_reg[exec.rd];
	assign op_b = exec.use_imm ? exec.imm : gpr_reg[exec.rr];

	always_comb
	begin
		sum = 9'h000;
		res = op_a;
		c_f = sf_reg[`CRF_SF_C];
		h_f = sf_reg[`CRF_SF_H];
		v_f = sf_reg[`CRF_SF_V];
		flags_upd = 1'b1;
		case (exec.alu_op)
			CRF_ALU_ADD:
			begin
				sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, exec.carry_in};
				res = sum[7:0];
				c_f = sum[8];
				h_f = (op_a[3] & op_b[3]) | (op_b[3] & ~res[3]) | (~res[3] & op_a[3]);
				v_f = (op_a[7] & op_b[7] & ~res[7]) | (~op_a[7] & ~op_b[7] & res[7]);
			end
			CRF_ALU_SUB:
			begin
				sum = {1'b0, op_a} - {1'b0, op_b} - {8'h00, exec.carry_in};
				res = sum[7:0];
				c_f = sum[8];
				h_f = (~op_a[3] & op_b[3]) | (op_b[3] & res[3]) | (res[3] & ~op_a[3]);
				v_f = (op_a[7] & ~op_b[7] & ~res[7]) | (~op_a[7] & op_b[7] & res[7]);
			end
			CRF_ALU_AND:
			begin
				res = op_a & op_b;
				v_f = 1'b0;
			end
			CRF_ALU_OR:
			begin
				res = op_a | op_b;
				v_f = 1'b0;
			end
			CRF_ALU_XOR:
			begin
				res = op_a ^ op_b;
				v_f = 1'b0;
			end
			CRF_ALU_MOV:
			begin
				res = op_b;
				flags_upd = 1'b0;
			end
			default:
			begin
				flags_upd = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// pointer pairs
	always_comb
	begin
		case (ptr_req.sel)
			2'd0: ptr_lo_idx = `CRF_PTR0_LO;
			2'd1: ptr_lo_idx = `CRF_PTR1_LO;
			default: ptr_lo_idx = `CRF_PTR2_LO;
		endcase
	end
	assign ptr_cur = {gpr_reg[ptr_lo_idx + 5'd1], gpr_reg[ptr_lo_idx]};

	always_comb
	begin
		ptr_new = ptr_cur;
		ptr_eff = ptr_cur;
		case (ptr_req.mode)
			CRF_PTR_DISP: ptr_eff = ptr_cur + {10'h000, ptr_req.disp};
			CRF_PTR_POSTINC: ptr_new = ptr_cur + 16'h0001;
			CRF_PTR_PREDEC:
			begin
				ptr_new = ptr_cur - 16'h0001;
				ptr_eff = ptr_new;
			end
			default: ptr_eff = ptr_cur;
		endcase
	end

	// ==========================================================
	// register file write port
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < `CRF_NUM_REGS; i++)
			begin
				gpr_reg[i] <= 8'h00;
			end
		end
		else
		begin
			if (exec.word_op)
			begin
				gpr_reg[{exec.rd[4:1], 1'b0}] <= exec.word_val[7:0];
				gpr_reg[{exec.rd[4:1], 1'b1}] <= exec.word_val[15:8];
			end
			else if (exec.alu_op != CRF_ALU_NONE)
			begin
				gpr_reg[exec.rd] <= res;
			end
			if (ctl.bit_load_instr)
			begin
				gpr_reg[ctl.reg_sel][ctl.bit_sel] <= sf_reg[`CRF_SF_T];
			end
			if (ptr_req.en && ptr_req.mode != CRF_PTR_DISP)
			begin
				gpr_reg[ptr_lo_idx] <= ptr_new[7:0];
				gpr_reg[ptr_lo_idx + 5'd1] <= ptr_new[15:8];
			end
		end
	end

	// ==========================================================
	// status flags
	assign bit_src = gpr_reg[ctl.reg_sel];
	assign take = pick_any && sf_reg[`CRF_SF_I] && !ctl.clear_irq_enable_instr
		&& !ctl.return_from_irq_instr;

	always_comb
	begin
		sf_next = sf_reg;
		if (ctl.sf_write)
		begin
			sf_next = ctl.sf_wdata;
		end
		if (flags_upd)
		begin
			sf_next[`CRF_SF_C] = c_f;
			sf_next[`CRF_SF_H] = h_f;
			sf_next[`CRF_SF_V] = v_f;
			sf_next[`CRF_SF_N] = res[7];
			sf_next[`CRF_SF_Z] = (res == 8'h00);
			sf_next[`CRF_SF_S] = res[7] ^ v_f;
		end
		if (ctl.bit_store_instr)
		begin
			sf_next[`CRF_SF_T] = bit_src[ctl.bit_sel];
		end
		if (ctl.set_irq_enable_instr || ctl.return_from_irq_instr)
		begin
			sf_next[`CRF_SF_I] = 1'b1;
		end
		if (ctl.clear_irq_enable_instr || take)
		begin
			sf_next[`CRF_SF_I] = 1'b0;
		end
	end

	// flags other than bit 7 kept as is on entry and return
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sf_reg <= `CRF_SF_RESET;
		end
		else
		begin
			sf_reg <= sf_next;
		end
	end

	// ==========================================================
	// interrupt priority
	crf_irq_pick #(
		.NSRC(NSRC),
		.VW(VW)
	) u_pick (
		.pending(irq_pending),
		.any(pick_any),
		.vec(pick_vec)
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_take <= 1'b0;
			irq_vec <= '0;
		end
		else
		begin
			irq_take <= take;
			irq_vec <= pick_vec;
		end
	end

	// ==========================================================
	// stack pointer and return address push
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sp_reg <= `CRF_SP_RESET;
			stack_we <= 1'b0;
			stack_addr <= 16'h0000;
			stack_data <= 16'h0000;
		end
		else
		begin
			stack_we <= 1'b0;
			if (sp_load)
			begin
				sp_reg <= sp_wdata;
			end
			else if (sp_op == CRF_SP_CALL || take)
			begin
				sp_reg <= sp_reg - `CRF_SP_RET;
				stack_we <= 1'b1;
				stack_addr <= sp_reg - `CRF_SP_BYTE;
				stack_data <= ret_pc;
			end
			else
			begin
				case (sp_op)
					CRF_SP_PUSH: sp_reg <= sp_reg - `CRF_SP_BYTE;
					CRF_SP_POP: sp_reg <= sp_reg + `CRF_SP_BYTE;
					CRF_SP_RET: sp_reg <= sp_reg + `CRF_SP_RET;
					default: sp_reg <= sp_reg;
				endcase
			end
		end
	end

	// ==========================================================
	// registered outputs and data-space decode
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data <= 8'h00;
			rr_data <= 8'h00;
			core_status_flags <= `CRF_SF_RESET;
			ptr_addr <= 16'h0000;
			ptr_is_reg <= 1'b0;
			ptr_is_io <= 1'b0;
			io_addr <= 6'h00;
			ptr_reg_data <= 8'h00;
			table_addr <= 16'h0000;
		end
		else
		begin
			rd_data <= op_a;
			rr_data <= op_b;
			core_status_flags <= sf_next;
			ptr_addr <= ptr_eff;
			ptr_is_reg <= ptr_req.en && ptr_eff <= `CRF_REG_LAST;
			ptr_is_io <= ptr_req.en && ptr_eff >= `CRF_IO_BASE && ptr_eff <= `CRF_IO_LAST;
			io_addr <= 6'(ptr_eff - `CRF_IO_BASE);
			ptr_reg_data <= (ptr_eff <= `CRF_REG_LAST) ? gpr_reg[ptr_eff[4:0]] : io_rdata;
			table_addr <= {gpr_reg[`CRF_PTR2_LO + 5'd1], gpr_reg[`CRF_PTR2_LO]};
		end
	end
endmodule : crf_core

/* verif/crf_core_asserts.sv */
`timescale 1ns/1ps
module crf_core_asserts
	import crf_pkg::*;
#(
	parameter int NSRC = 8,
	parameter int VW = 3
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] fetch_word,
	input wire logic advance,
	input wire crf_exec_t exec,
	input wire crf_ctl_t ctl,
	input wire crf_sp_op_t sp_op,
	input wire logic sp_load,
	input wire logic [15:0] ret_pc,
	input wire logic [NSRC-1:0] irq_pending,
	input wire logic [15:0] instr_reg,
	input wire logic [7:0] core_status_flags,
	input wire logic [15:0] ptr_addr,
	input wire logic ptr_is_io,
	input wire logic [5:0] io_addr,
	input wire logic [15:0] sp_reg,
	input wire logic [15:0] stack_data,
	input wire logic stack_we,
	input wire logic irq_take,
	input wire logic [VW-1:0] irq_vec
);
	// ==========
	// pending sources seen at the taking edge
	logic [NSRC-1:0] pend_q;
	logic [NSRC-1:0] low_mask;
	assign low_mask = (NSRC'(1) << irq_vec) - NSRC'(1);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pend_q <= '0;
		else
			pend_q <= irq_pending;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_take_gated: assert property (
		irq_take |-> $past(core_status_flags[7]) && !$past(ctl.clear_irq_enable_instr)
		&& pend_q != '0)
		else $error("interrupt taken while disabled");
	a_take_clears: assert property (
		irq_take |-> !core_status_flags[7])
		else $error("enable left set on interrupt");
	a_take_push: assert property (
		irq_take && !$past(sp_load) |-> stack_we && stack_data == $past(ret_pc)
		&& sp_reg == $past(sp_reg) - 16'h0002)
		else $error("return address not pushed");
	a_lowest_vec: assert property (
		irq_take |-> pend_q[irq_vec] && (pend_q & low_mask) == '0)
		else $error("wrong vector chosen");
	a_sign_xor: assert property (
		$past(exec.alu_op) inside {CRF_ALU_ADD, CRF_ALU_SUB, CRF_ALU_AND, CRF_ALU_OR,
		CRF_ALU_XOR} && !$past(ctl.sf_write) |->
		core_status_flags[4] == (core_status_flags[2] ^ core_status_flags[3]))
		else $error("sign flag not n xor v");
	a_push_step: assert property (
		sp_op == CRF_SP_PUSH && !sp_load ##1 !irq_take |-> sp_reg == $past(sp_reg) - 16'h0001)
		else $error("push step wrong");
	a_clear_blocks: assert property (
		ctl.clear_irq_enable_instr && !ctl.sf_write |=> !irq_take && !core_status_flags[7])
		else $error("clear enable ignored");
	a_sei_sets: assert property (
		ctl.set_irq_enable_instr && !ctl.clear_irq_enable_instr && !ctl.sf_write
		##1 !irq_take |-> core_status_flags[7])
		else $error("set enable ignored");
	a_fetch_latch: assert property (
		advance |=> instr_reg == $past(fetch_word))
		else $error("fetched word not latched");
	a_io_map: assert property (
		ptr_is_io |-> ptr_addr inside {[16'h0020:16'h005F]} && io_addr == 6'(ptr_addr - 16'h0020))
		else $error("io window mapping wrong");
endmodule : crf_core_asserts

bind crf_core crf_core_asserts #(.NSRC(NSRC), .VW(VW)) i_chk (.clk(clk), .rst_n(rst_n),
	.fetch_word(fetch_word), .advance(advance), .exec(exec), .ctl(ctl), .sp_op(sp_op),
	.sp_load(sp_load), .ret_pc(ret_pc), .irq_pending(irq_pending), .instr_reg(instr_reg),
	.core_status_flags(core_status_flags), .ptr_addr(ptr_addr), .ptr_is_io(ptr_is_io),
	.io_addr(io_addr), .sp_reg(sp_reg), .stack_data(stack_data), .stack_we(stack_we),
	.irq_take(irq_take), .irq_vec(irq_vec));

/* verif/crf_prog_model.sv */
`timescale 1ns/1ps
module crf_prog_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic advance,
	input wire logic [5:0] io_addr,
	output logic [15:0] fetch_word,
	output logic [7:0] io_rdata
);
	// ==========
	// program words differ at every address
	logic [15:0] pc_reg;
	assign fetch_word = pc_reg ^ 16'hC35A;
	assign io_rdata = {2'b10, io_addr};
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pc_reg <= 16'h0000;
		else if (advance)
			pc_reg <= pc_reg + 16'h0001;
	end
endmodule : crf_prog_model

/* verif/cpu_regfile_status_flags_test.sv */
`timescale 1ns/1ps
module cpu_regfile_status_flags_test
	import crf_pkg::*;
;
	logic clk, rst_n, advance, sp_load, ptr_is_reg, ptr_is_io, stack_we, irq_take;
	logic [15:0] fetch_word, sp_wdata, ret_pc, instr_reg, ptr_addr, table_addr, sp_reg, stack_data;
	logic [7:0] irq_pending, io_rdata, rd_data, rr_data, core_status_flags, ptr_reg_data, f;
	logic [5:0] io_addr;
	logic [15:0] stack_addr;
	logic [2:0] irq_vec;
	crf_exec_t exec;
	crf_ptr_req_t ptr_req;
	crf_ctl_t ctl;
	crf_sp_op_t sp_op;
	int num_errors, n_tests;
	crf_core #(.NSRC(8), .VW(3)) i_dut (.clk(clk), .rst_n(rst_n), .fetch_word(fetch_word),
		.advance(advance), .exec(exec), .ptr_req(ptr_req), .ctl(ctl), .sp_op(sp_op),
		.sp_load(sp_load), .sp_wdata(sp_wdata), .ret_pc(ret_pc), .irq_pending(irq_pending),
		.io_rdata(io_rdata), .instr_reg(instr_reg), .rd_data(rd_data), .rr_data(rr_data),
		.core_status_flags(core_status_flags), .ptr_addr(ptr_addr), .ptr_is_reg(ptr_is_reg),
		.ptr_is_io(ptr_is_io), .io_addr(io_addr), .ptr_reg_data(ptr_reg_data),
		.table_addr(table_addr), .sp_reg(sp_reg), .stack_addr(stack_addr), .stack_data(stack_data),
		.stack_we(stack_we), .irq_take(irq_take), .irq_vec(irq_vec));
	crf_prog_model i_prog (.clk(clk), .rst_n(rst_n), .advance(advance), .io_addr(io_addr),
		.fetch_word(fetch_word), .io_rdata(io_rdata));
	// ==========
	// shared tasks
	task automatic cyc();
		@(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic op(input crf_alu_op_t o, input logic [4:0] d, r, input logic im,
		input logic [7:0] v);
		exec = '{o, d, r, im, v, 1'b0, 1'b0, 16'h0000};
		cyc();
	endtask : op
	task automatic wword(input logic [4:0] d, input logic [15:0] w);
		exec = '{CRF_ALU_NONE, d, 5'h00, 1'b0, 8'h00, 1'b0, 1'b1, w};
		cyc();
		exec = '0;
	endtask : wword
	task automatic test_done();
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	// ==========
	// scenarios
	task automatic t_fetch();
		logic [15:0] w;
		advance = 1'b1;
		w = fetch_word;
		cyc();
		chk("instr", w, instr_reg);
		w = fetch_word;
		cyc();
		advance = 1'b0;
		chk("instr next", w, instr_reg);
	endtask : t_fetch
	task automatic t_alu();
		op(CRF_ALU_MOV, 5'd1, 5'd0, 1'b1, 8'h7F);
		op(CRF_ALU_MOV, 5'd2, 5'd0, 1'b1, 8'h01);
		op(CRF_ALU_ADD, 5'd1, 5'd2, 1'b0, 8'h00);
		chk("flags add", 16'h002C, 16'(core_status_flags));
		op(CRF_ALU_NONE, 5'd1, 5'd2, 1'b0, 8'h00);
		chk("rd", 16'h0080, 16'(rd_data));
		chk("rr", 16'h0001, 16'(rr_data));
		op(CRF_ALU_SUB, 5'd2, 5'd2, 1'b0, 8'h00);
		chk("flags sub", 16'h0002, 16'(core_status_flags));
		op(CRF_ALU_MOV, 5'd4, 5'd0, 1'b1, 8'h80);
		op(CRF_ALU_ADD, 5'd4, 5'd4, 1'b0, 8'h00);
		chk("flags carry", 16'h001B, 16'(core_status_flags));
		op(CRF_ALU_AND, 5'd1, 5'd0, 1'b1, 8'h80);
		chk("flags and", 16'h0015, 16'(core_status_flags));
		op(CRF_ALU_XOR, 5'd1, 5'd0, 1'b1, 8'h80);
		chk("flags xor", 16'h0003, 16'(core_status_flags));
		op(CRF_ALU_OR, 5'd1, 5'd0, 1'b1, 8'h80);
		chk("flags or", 16'h0015, 16'(core_status_flags));
		exec = '{CRF_ALU_ADD, 5'd5, 5'd5, 1'b1, 8'h00, 1'b1, 1'b0, 16'h0000};
		cyc();
		chk("flags cin", 16'h0000, 16'(core_status_flags));
	endtask : t_alu
	task automatic t_ptr();
		wword(5'd26, 16'h0001);
		ptr_req = '{1'b1, 2'd0, CRF_PTR_POSTINC, 6'h00};
		cyc();
		chk("post addr", 16'h0001, ptr_addr);
		chk("is reg", 16'h0001, 16'(ptr_is_reg));
		chk("reg data", 16'h0080, 16'(ptr_reg_data));
		ptr_req = '{1'b1, 2'd0, CRF_PTR_PREDEC, 6'h00};
		cyc();
		chk("pre addr", 16'h0001, ptr_addr);
		ptr_req = '0;
		wword(5'd28, 16'h0040);
		ptr_req = '{1'b1, 2'd1, CRF_PTR_DISP, 6'h1F};
		cyc();
		chk("disp addr", 16'h005F, ptr_addr);
		chk("is io", 16'h0001, 16'(ptr_is_io));
		chk("io addr", 16'h003F, 16'(io_addr));
		ptr_req = '0;
		wword(5'd30, 16'h1234);
		cyc();
		chk("table", 16'h1234, table_addr);
		op(CRF_ALU_NONE, 5'd30, 5'd31, 1'b0, 8'h00);
		chk("pair", 16'h1234, {rr_data, rd_data});
	endtask : t_ptr
	task automatic t_bits();
		ctl = '{1'b1, 1'b0, 5'd1, 3'd7, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
		cyc();
		chk("t bit", 16'h0001, 16'(core_status_flags[6]));
		ctl = '{1'b0, 1'b1, 5'd3, 3'd0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
		cyc();
		ctl = '0;
		op(CRF_ALU_NONE, 5'd3, 5'd0, 1'b0, 8'h00);
		chk("bit load", 16'h0001, 16'(rd_data));
		ctl = '{1'b0, 1'b0, 5'd0, 3'd0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h3C};
		cyc();
		ctl = '0;
		chk("flags write", 16'h003C, 16'(core_status_flags));
	endtask : t_bits
	task automatic t_irq();
		sp_load = 1'b1;
		sp_wdata = 16'h00F0;
		cyc();
		sp_load = 1'b0;
		sp_op = CRF_SP_PUSH;
		chk("sp load", 16'h00F0, sp_reg);
		cyc();
		sp_op = CRF_SP_POP;
		chk("sp push", 16'h00EF, sp_reg);
		cyc();
		sp_op = CRF_SP_NONE;
		irq_pending = 8'h06;
		chk("sp pop", 16'h00F0, sp_reg);
		cyc();
		chk("gated", 16'h0000, 16'(irq_take));
		ctl = '{1'b0, 1'b0, 5'd0, 3'd0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00};
		ret_pc = 16'hABCD;
		cyc();
		ctl = '0;
		f = core_status_flags;
		chk("sei", 16'h0001, 16'(f[7]));
		cyc();
		irq_pending = 8'h00;
		chk("take", 16'h0001, 16'(irq_take));
		chk("vec", 16'h0001, 16'(irq_vec));
		chk("i off", 16'h0000, 16'(core_status_flags[7]));
		chk("flags kept", 16'(f[6:0]), 16'(core_status_flags[6:0]));
		chk("push we", 16'h0001, 16'(stack_we));
		chk("push pc", 16'hABCD, stack_data);
		chk("push addr", 16'h00EF, stack_addr);
		chk("sp call", 16'h00EE, sp_reg);
		ctl = '{1'b0, 1'b0, 5'd0, 3'd0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00};
		sp_op = CRF_SP_RET;
		cyc();
		chk("irq return", 16'h0001, 16'(core_status_flags[7]));
		chk("sp ret", 16'h00F0, sp_reg);
		ctl = '{1'b0, 1'b0, 5'd0, 3'd0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00};
		sp_op = CRF_SP_NONE;
		irq_pending = 8'h80;
		cyc();
		chk("clear take", 16'h0000, 16'(irq_take));
		chk("clear irq", 16'h0000, 16'(core_status_flags[7]));
		ctl = '0;
		irq_pending = 8'h00;
		sp_op = CRF_SP_CALL;
		ret_pc = 16'h1357;
		cyc();
		sp_op = CRF_SP_NONE;
		chk("call we", 16'h0001, 16'(stack_we));
		chk("call pc", 16'h1357, stack_data);
		chk("call sp", 16'h00EE, sp_reg);
	endtask : t_irq
	task automatic t_reset();
		advance = 1'b1;
		cyc();
		rst_n = 1'b0;
		#1;
		chk("mid reset instr", 16'h0000, instr_reg);
		chk("mid reset sp", 16'h0000, sp_reg);
		advance = 1'b0;
		cyc();
		rst_n = 1'b1;
		op(CRF_ALU_NONE, 5'd1, 5'd0, 1'b0, 8'h00);
		chk("mid reset regs", 16'h0000, 16'(rd_data));
	endtask : t_reset
	// ==========
	// clock, reset, sequence
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#5000;
		num_errors++;
		test_done();
	end
	initial
	begin
		rst_n = 1'b0;
		advance = 1'b0;
		sp_load = 1'b0;
		sp_wdata = 16'h0000;
		ret_pc = 16'h0000;
		irq_pending = 8'h00;
		exec = '0;
		ptr_req = '0;
		ctl = '0;
		sp_op = CRF_SP_NONE;
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk("reset flags", 16'h0000, 16'(core_status_flags));
		chk("reset sp", 16'h0000, sp_reg);
		t_fetch();
		t_alu();
		t_ptr();
		t_bits();
		t_irq();
		t_reset();
		test_done();
	end
endmodule : cpu_regfile_status_flags_test
